// *** src/mie_core.sv ***
`timescale 1ns/10ps
// Function
// - both preclear halves run: clear watchdog, timeout and power-down flags
// - one preclear half alone: remember it, leave watchdog and flags alone
// - memory invert: complement byte back to memory, zero flag only
// - invert to accumulator: complement into accumulator, memory kept, zero only
// - bcd adjust low nibble: add 6 if above 9 or half carry set
// - bcd adjust high nibble plus digit carry: add 6 and set carry if above 9 or carry set, store
// - minus one to memory or accumulator, zero flag only
// - plus one to memory or accumulator, zero flag only
// - power down: stop execution, stop clock, keep storage, pc plus one
// - power down: clear watchdog and prescaler, power-down set, timeout clear
// - direct branch loads pc from instruction, flags kept
// - copies between immediate, memory and accumulator leave flags alone
// - idle instruction only advances pc by one
// - union: or accumulator with byte or immediate, zero flag only
// - subroutine exit pops pc, two instruction cycles, flags kept
// - exit with literal pops pc and loads immediate into accumulator
// - interrupt exit pops pc and sets global interrupt enable
// - rotate left, bit 7 into bit 0, to memory or accumulator
// - any load of pc low byte costs one extra four-clock cycle
module mie_core (
	input  wire logic                       clk_i,
	input  wire logic                       rst_n_i,
	output      logic [mie_pkg::PC_W-1:0]   prog_addr_o,
	input  wire logic [mie_pkg::IW-1:0]     prog_data_i,
	output      mie_pkg::mie_dmem_req_t     dmem_req_o,
	input  wire logic [mie_pkg::DW-1:0]     dmem_rdata_i,
	output      logic                       halted_o,
	input  wire logic [mie_pkg::AXI_AW-1:0] s_axi_awaddr_i,
	input  wire logic                       s_axi_awvalid_i,
	output      logic                       s_axi_awready_o,
	input  wire logic [31:0]                s_axi_wdata_i,
	input  wire logic [3:0]                 s_axi_wstrb_i,
	input  wire logic                       s_axi_wvalid_i,
	output      logic                       s_axi_wready_o,
	output      logic [1:0]                 s_axi_bresp_o,
	output      logic                       s_axi_bvalid_o,
	input  wire logic                       s_axi_bready_i,
	input  wire logic [mie_pkg::AXI_AW-1:0] s_axi_araddr_i,
	input  wire logic                       s_axi_arvalid_i,
	output      logic                       s_axi_arready_o,
	output      logic [31:0]                s_axi_rdata_o,
	output      logic [1:0]                 s_axi_rresp_o,
	output      logic                       s_axi_rvalid_o,
	input  wire logic                       s_axi_rready_i
);
	import mie_pkg::*;

	mie_state_t        state_reg;
	logic [1:0]        phase_reg;
	logic              long_reg;
	logic [PC_W-1:0]   pc_reg;
	logic [IW-1:0]     instr_reg;
	logic [DW-1:0]     acc_reg;
	mie_flags_t        flags_reg;
	logic              pre1_reg;
	logic              pre2_reg;
	logic [WD_W-1:0]   presc_reg;
	logic [WD_W-1:0]   wdt_reg;
	logic [PC_W-1:0]   stk_mem [STK_DEPTH];
	logic [SP_W-1:0]   sp_reg;
	logic [AXI_AW-1:0] aw_addr_reg;
	logic [31:0]       w_data_reg;
	logic              w_lane0_reg;

	logic [4:0]      op_w;
	logic [DW-1:0]   m_w;
	logic [DW-1:0]   opr_w;
	logic            exec_w;
	logic            running_w;
	logic            pair_clear_w;
	logic            wd_tick_w;
	logic [PC_W-1:0] stk_top_w;
	logic [DW-1:0]   res_w;
	logic            mem_wr_w;
	logic            acc_wr_w;
	logic            zero_upd_w;
	logic            pop_w;
	logic            emi_set_w;
	logic            pc_long_w;
	logic [PC_W-1:0] pc_next;
	logic [4:0]      bcd_lo_w;
	logic [4:0]      bcd_hi_w;
	logic            digit_carry_w;
	logic            bcd_carry_w;
	logic            wr_fire_w;
	logic            sw_wr_w;
	logic            sw_ctrl_wr;
	logic            sw_pc_wr;
	logic            sw_acc_wr;
	logic            sw_flags_wr;
	logic            sw_stack_wr;
	logic            wr_hit_w;
	logic [31:0]     status_w;
	logic [31:0]     rd_data_w;
	logic            rd_hit_w;

	assign op_w      = instr_reg[OP_MSB:OP_LSB];
	assign m_w       = instr_reg[ARG_MSB:0];
	assign exec_w    = (state_reg == ST_RUN) && (phase_reg == PH_EXEC);
	assign running_w = (state_reg == ST_RUN) || (state_reg == ST_EXTRA);
	// the low pc byte reads through the data space like any byte
	assign opr_w     = (m_w == PCL_ADDR) ? pc_reg[DW-1:0] : dmem_rdata_i;
	assign stk_top_w = stk_mem[sp_reg[2:0] - IDX_ONE];

	// bcd adjust datapath
	always_comb
	begin
		bcd_lo_w      = {1'b0, acc_reg[3:0]};
		digit_carry_w = 1'b0;
		// digit carry is the inverted half carry, not the adder's carry out
		if ((bcd_lo_w > BCD_LIMIT) || flags_reg.half_carry_flag)
		begin
			bcd_lo_w      = bcd_lo_w + BCD_STEP;
			digit_carry_w = !flags_reg.half_carry_flag;
		end
		bcd_hi_w      = {1'b0, acc_reg[7:4]} + {4'h0, digit_carry_w};
		bcd_carry_w   = flags_reg.carry;
		if ((bcd_hi_w > BCD_LIMIT) || flags_reg.carry)
		begin
			bcd_hi_w    = bcd_hi_w + BCD_STEP;
			bcd_carry_w = 1'b1;
		end
	end

	always_comb
	begin
		res_w      = opr_w;
		mem_wr_w   = 1'b0;
		acc_wr_w   = 1'b0;
		zero_upd_w = 1'b0;
		pop_w      = 1'b0;
		emi_set_w  = 1'b0;
		pc_long_w  = 1'b0;
		pc_next    = pc_reg + PC_STEP;
		case (op_w)
			OP_MEM_INVERT: begin res_w = ~opr_w; mem_wr_w = 1'b1; zero_upd_w = 1'b1; end
			OP_INV_ACC:    begin res_w = ~opr_w; acc_wr_w = 1'b1; zero_upd_w = 1'b1; end
			OP_BCD_ADJ:    begin res_w = {bcd_hi_w[3:0], bcd_lo_w[3:0]}; mem_wr_w = 1'b1; end
			OP_MEM_MINUS:  begin res_w = opr_w - BYTE_ONE; mem_wr_w = 1'b1; zero_upd_w = 1'b1; end
			OP_MINUS_ACC:  begin res_w = opr_w - BYTE_ONE; acc_wr_w = 1'b1; zero_upd_w = 1'b1; end
			OP_MEM_PLUS:   begin res_w = opr_w + BYTE_ONE; mem_wr_w = 1'b1; zero_upd_w = 1'b1; end
			OP_PLUS_ACC:   begin res_w = opr_w + BYTE_ONE; acc_wr_w = 1'b1; zero_upd_w = 1'b1; end
			OP_BRANCH:     begin pc_next = instr_reg[PC_W-1:0]; pc_long_w = 1'b1; end
			OP_LOAD_ACC:   acc_wr_w = 1'b1;
			OP_LOAD_IMM:   begin res_w = m_w; acc_wr_w = 1'b1; end
			OP_STORE_ACC:  begin res_w = acc_reg; mem_wr_w = 1'b1; end
			OP_UNION_ACC:  begin res_w = acc_reg | opr_w; acc_wr_w = 1'b1; zero_upd_w = 1'b1; end
			OP_UNION_IMM:  begin res_w = acc_reg | m_w; acc_wr_w = 1'b1; zero_upd_w = 1'b1; end
			OP_UNION_MEM:  begin res_w = acc_reg | opr_w; mem_wr_w = 1'b1; zero_upd_w = 1'b1; end
			OP_SUB_EXIT:   begin pc_next = stk_top_w; pop_w = 1'b1; pc_long_w = 1'b1; end
			OP_EXIT_LIT:
			begin
				pc_next   = stk_top_w;
				pop_w     = 1'b1;
				pc_long_w = 1'b1;
				res_w     = m_w;
				acc_wr_w  = 1'b1;
			end
			OP_IRQ_EXIT:
			begin
				pc_next   = stk_top_w;
				pop_w     = 1'b1;
				pc_long_w = 1'b1;
				emi_set_w = 1'b1;
			end
			OP_ROT_MEM:    begin res_w = {opr_w[6:0], opr_w[7]}; mem_wr_w = 1'b1; end
			OP_ROT_ACC:    begin res_w = {opr_w[6:0], opr_w[7]}; acc_wr_w = 1'b1; end
			default:       ;
		endcase
		// a store to the pc low byte goes to the pc, not to the ram
		if (mem_wr_w && (m_w == PCL_ADDR))
		begin
			pc_next   = {pc_reg[PC_W-1:DW], res_w};
			pc_long_w = 1'b1;
		end
	end

	// sequencing: four clocks per instruction cycle
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			state_reg <= ST_IDLE;
			phase_reg <= PH_FETCH;
			long_reg  <= 1'b0;
		end
		else if (sw_ctrl_wr && !w_data_reg[CTRL_RUN])
			state_reg <= ST_IDLE;
		else if (sw_ctrl_wr && !running_w)
		begin
			state_reg <= ST_RUN;
			phase_reg <= PH_FETCH;
		end
		else
		begin
			case (state_reg)
				ST_RUN:
				begin
					phase_reg <= phase_reg + PH_ONE;
					if (exec_w)
						long_reg <= pc_long_w;
					if (exec_w && (op_w == OP_POWER_DOWN))
						state_reg <= ST_HALT;
					else if ((phase_reg == PH_LAST) && long_reg)
						state_reg <= ST_EXTRA;
				end
				ST_EXTRA:
				begin
					phase_reg <= phase_reg + PH_ONE;
					long_reg  <= 1'b0;
					if (phase_reg == PH_LAST)
						state_reg <= ST_RUN;
				end
				ST_HALT:  phase_reg <= PH_FETCH;
				ST_IDLE:  phase_reg <= PH_FETCH;
				default:  state_reg <= ST_IDLE;
			endcase
		end
	end

	// halted_o doubles as the request to stop the system clock
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			halted_o <= 1'b0;
		else
			halted_o <= (state_reg == ST_HALT);
	end

	// memory ports; memories answer combinationally, in the same clock the address is on the port
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			prog_addr_o <= '0;
			instr_reg   <= '0;
			dmem_req_o  <= '0;
		end
		else if (state_reg == ST_RUN)
		begin
			case (phase_reg)
				PH_FETCH:  prog_addr_o <= pc_reg;
				PH_DECODE:
				begin
					instr_reg       <= prog_data_i;
					dmem_req_o.addr <= prog_data_i[ARG_MSB:0];
				end
				PH_EXEC:
				begin
					dmem_req_o.we    <= mem_wr_w && (m_w != PCL_ADDR);
					dmem_req_o.wdata <= res_w;
				end
				default:   dmem_req_o.we <= 1'b0;
			endcase
		end
		else
			dmem_req_o.we <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			pc_reg <= '0;
		else if (sw_pc_wr)
			pc_reg <= w_data_reg[PC_W-1:0];
		else if (exec_w)
			pc_reg <= pc_next;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			acc_reg <= BYTE_ZERO;
		else if (sw_acc_wr)
			acc_reg <= w_data_reg[DW-1:0];
		else if (exec_w && acc_wr_w)
			acc_reg <= res_w;
	end

	// stack: software may preload return addresses
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			sp_reg <= '0;
		else if (exec_w && pop_w && (sp_reg != '0))
			sp_reg <= sp_reg - SP_ONE;
		else if (sw_stack_wr && (sp_reg != SP_FULL))
			sp_reg <= sp_reg + SP_ONE;
	end

	always_ff @(posedge clk_i)
	begin
		if (sw_stack_wr && (sp_reg != SP_FULL) && !(exec_w && pop_w))
			stk_mem[sp_reg[2:0]] <= w_data_reg[PC_W-1:0];
	end

	// watchdog with prescaler, frozen while powered down
	assign pair_clear_w = exec_w && (((op_w == OP_PRECLR1) && pre2_reg)
		|| ((op_w == OP_PRECLR2) && pre1_reg));
	assign wd_tick_w = (state_reg != ST_HALT) && (presc_reg == WD_MAX) && (wdt_reg == WD_MAX);

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			presc_reg <= WD_CLEAR;
			wdt_reg   <= WD_CLEAR;
		end
		else if (pair_clear_w || (exec_w && (op_w == OP_POWER_DOWN)))
		begin
			presc_reg <= WD_CLEAR;
			wdt_reg   <= WD_CLEAR;
		end
		else if (state_reg != ST_HALT)
		begin
			presc_reg <= presc_reg + WD_ONE;
			if (presc_reg == WD_MAX)
				wdt_reg <= wdt_reg + WD_ONE;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			pre1_reg <= 1'b0;
			pre2_reg <= 1'b0;
		end
		else if (pair_clear_w)
		begin
			pre1_reg <= 1'b0;
			pre2_reg <= 1'b0;
		end
		else if (exec_w && (op_w == OP_PRECLR1))
			pre1_reg <= 1'b1;
		else if (exec_w && (op_w == OP_PRECLR2))
			pre2_reg <= 1'b1;
	end

	// flags hold unless named below; a timeout beats any clear
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			flags_reg <= '0;
		else
		begin
			if (exec_w)
			begin
				if (zero_upd_w)
					flags_reg.zero <= (res_w == BYTE_ZERO);
				if (op_w == OP_BCD_ADJ)
					flags_reg.carry <= bcd_carry_w;
				if (emi_set_w)
					flags_reg.global_irq_enable <= 1'b1;
				if (op_w == OP_POWER_DOWN)
				begin
					flags_reg.power_down_flag       <= 1'b1;
					flags_reg.watchdog_timeout_flag <= 1'b0;
				end
				if (pair_clear_w)
				begin
					flags_reg.power_down_flag       <= 1'b0;
					flags_reg.watchdog_timeout_flag <= 1'b0;
				end
			end
			// software wins its own bits only; power-down and timeout stay with the core
			if (sw_flags_wr)
			begin
				flags_reg.zero              <= w_data_reg[FB_ZERO];
				flags_reg.carry             <= w_data_reg[FB_CARRY];
				flags_reg.half_carry_flag   <= w_data_reg[FB_HC];
				flags_reg.global_irq_enable <= w_data_reg[FB_EMI];
			end
			if (wd_tick_w)
				flags_reg.watchdog_timeout_flag <= 1'b1;
		end
	end

	// axi4-lite write: address and data taken in any order
	assign wr_fire_w   = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
	assign sw_wr_w     = wr_fire_w && w_lane0_reg;
	assign sw_ctrl_wr  = sw_wr_w && (aw_addr_reg == REG_CTRL);
	assign sw_pc_wr    = sw_wr_w && (aw_addr_reg == REG_PC);
	assign sw_acc_wr   = sw_wr_w && (aw_addr_reg == REG_ACC);
	assign sw_flags_wr = sw_wr_w && (aw_addr_reg == REG_FLAGS);
	assign sw_stack_wr = sw_wr_w && (aw_addr_reg == REG_STACK);
	assign wr_hit_w    = (aw_addr_reg == REG_CTRL) || (aw_addr_reg == REG_PC)
		|| (aw_addr_reg == REG_ACC) || (aw_addr_reg == REG_FLAGS)
		|| (aw_addr_reg == REG_STACK) || (aw_addr_reg == REG_WDT);

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= RESP_OKAY;
			aw_addr_reg     <= '0;
			w_data_reg      <= '0;
			w_lane0_reg     <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid_i && s_axi_awready_o)
			begin
				aw_addr_reg     <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o)
			begin
				w_data_reg     <= s_axi_wdata_i;
				w_lane0_reg    <= s_axi_wstrb_i[0];
				s_axi_wready_o <= 1'b0;
			end
			if (wr_fire_w)
			begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= wr_hit_w ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid_o && s_axi_bready_i)
			begin
				s_axi_bvalid_o  <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o  <= 1'b1;
			end
		end
	end

	always_comb
	begin
		status_w           = '0;
		status_w[FB_ZERO]  = flags_reg.zero;
		status_w[FB_CARRY] = flags_reg.carry;
		status_w[FB_HC]    = flags_reg.half_carry_flag;
		status_w[FB_PDF]   = flags_reg.power_down_flag;
		status_w[FB_TMO]   = flags_reg.watchdog_timeout_flag;
		status_w[FB_EMI]   = flags_reg.global_irq_enable;
		status_w[FB_HALT]  = (state_reg == ST_HALT);
		status_w[FB_PRE1]  = pre1_reg;
		status_w[FB_PRE2]  = pre2_reg;
		rd_hit_w           = 1'b1;
		rd_data_w          = '0;
		case (s_axi_araddr_i)
			REG_CTRL:  rd_data_w[CTRL_RUN] = running_w;
			REG_PC:    rd_data_w[PC_W-1:0] = pc_reg;
			REG_ACC:   rd_data_w[DW-1:0] = acc_reg;
			REG_FLAGS: rd_data_w = status_w;
			REG_STACK: rd_data_w[SP_W-1:0] = sp_reg;
			REG_WDT:   rd_data_w[WD_W-1:0] = wdt_reg;
			default:   rd_hit_w = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= '0;
			s_axi_rresp_o   <= RESP_OKAY;
		end
		else if (s_axi_arvalid_i && s_axi_arready_o)
		begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rdata_o   <= rd_data_w;
			s_axi_rresp_o   <= rd_hit_w ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid_o && s_axi_rready_i)
		begin
			s_axi_rvalid_o  <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end

	sequence s_exec_op(logic [4:0] code);
		exec_w && (op_w == code);
	endsequence

	sequence s_extra_run;
		(state_reg == ST_EXTRA) [*4] ##1 (state_reg == ST_RUN);
	endsequence

	preclear_pair_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		pair_clear_w && !wd_tick_w |=> (wdt_reg == WD_CLEAR) && !pre1_reg
		&& !flags_reg.watchdog_timeout_flag && !flags_reg.power_down_flag)
		else $error("preclear pair did not clear watchdog");
	preclear_single_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_exec_op(OP_PRECLR1) ##0 !pre2_reg && !wd_tick_w |=> pre1_reg
		&& $stable(flags_reg.watchdog_timeout_flag) && $stable(flags_reg.power_down_flag))
		else $error("single preclear changed flags");
	invert_mem_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_exec_op(OP_MEM_INVERT) ##0 (m_w != PCL_ADDR) |=> dmem_req_o.we
		&& (dmem_req_o.wdata == ~$past(opr_w)) ##1 !dmem_req_o.we)
		else $error("memory invert wrote wrong byte");
	bcd_carry_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_exec_op(OP_BCD_ADJ) ##0 flags_reg.carry && !sw_flags_wr |=> flags_reg.carry)
		else $error("bcd adjust dropped carry");
	halt_entry_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_exec_op(OP_POWER_DOWN) ##0 !wd_tick_w && !sw_wr_w |=> (state_reg == ST_HALT)
		&& flags_reg.power_down_flag && !flags_reg.watchdog_timeout_flag ##1 halted_o)
		else $error("power down entry wrong");
	branch_pc_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_exec_op(OP_BRANCH) ##0 !sw_wr_w |=> pc_reg == $past(instr_reg[PC_W-1:0]))
		else $error("branch target not loaded");
	idle_pc_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_exec_op(OP_IDLE) ##0 !sw_wr_w |=> (pc_reg == $past(pc_reg) + PC_STEP)
		&& $stable(acc_reg) && $stable(flags_reg.zero) && $stable(flags_reg.carry))
		else $error("idle changed state");
	irq_exit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_exec_op(OP_IRQ_EXIT) ##0 !sw_wr_w |=> flags_reg.global_irq_enable)
		else $error("interrupt exit left enable clear");
	// a software stop may legally cut the extra cycle short
	extra_cycle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i || sw_ctrl_wr)
		(state_reg == ST_RUN) && (phase_reg == PH_LAST) && long_reg && !sw_wr_w
		|=> s_extra_run)
		else $error("extra cycle not four clocks");
endmodule

// *** src/mie_pkg.sv ***
package mie_pkg;
	localparam int PC_W      = 11;
	localparam int DW        = 8;
	localparam int IW        = 16;
	localparam int AXI_AW    = 8;
	localparam int STK_DEPTH = 8;
	localparam int SP_W      = 4;
	localparam int WD_W      = 8;

	// instruction word: opcode, then an 8-bit argument; a branch takes all 11 low bits
	localparam int OP_MSB  = 15;
	localparam int OP_LSB  = 11;
	localparam int ARG_MSB = 7;

	localparam logic [4:0] OP_IDLE       = 5'h00;
	localparam logic [4:0] OP_PRECLR1    = 5'h01;
	localparam logic [4:0] OP_PRECLR2    = 5'h02;
	localparam logic [4:0] OP_MEM_INVERT = 5'h03;
	localparam logic [4:0] OP_INV_ACC    = 5'h04;
	localparam logic [4:0] OP_BCD_ADJ    = 5'h05;
	localparam logic [4:0] OP_MEM_MINUS  = 5'h06;
	localparam logic [4:0] OP_MINUS_ACC  = 5'h07;
	localparam logic [4:0] OP_MEM_PLUS   = 5'h08;
	localparam logic [4:0] OP_PLUS_ACC   = 5'h09;
	localparam logic [4:0] OP_POWER_DOWN = 5'h0A;
	localparam logic [4:0] OP_BRANCH     = 5'h0B;
	localparam logic [4:0] OP_LOAD_ACC   = 5'h0C;
	localparam logic [4:0] OP_LOAD_IMM   = 5'h0D;
	localparam logic [4:0] OP_STORE_ACC  = 5'h0E;
	localparam logic [4:0] OP_UNION_ACC  = 5'h0F;
	localparam logic [4:0] OP_UNION_IMM  = 5'h10;
	localparam logic [4:0] OP_UNION_MEM  = 5'h11;
	localparam logic [4:0] OP_SUB_EXIT   = 5'h12;
	localparam logic [4:0] OP_EXIT_LIT   = 5'h13;
	localparam logic [4:0] OP_IRQ_EXIT   = 5'h14;
	localparam logic [4:0] OP_ROT_MEM    = 5'h15;
	localparam logic [4:0] OP_ROT_ACC    = 5'h16;

	localparam logic [1:0] PH_FETCH  = 2'h0;
	localparam logic [1:0] PH_DECODE = 2'h1;
	localparam logic [1:0] PH_EXEC   = 2'h2;
	localparam logic [1:0] PH_LAST   = 2'h3;
	localparam logic [1:0] PH_ONE    = 2'h1;

	localparam logic [DW-1:0]   PCL_ADDR  = 8'h06;
	localparam logic [DW-1:0]   BYTE_ONE  = 8'h01;
	localparam logic [DW-1:0]   BYTE_ZERO = 8'h00;
	localparam logic [PC_W-1:0] PC_STEP   = 11'h001;
	localparam logic [4:0]      BCD_LIMIT = 5'h09;
	localparam logic [4:0]      BCD_STEP  = 5'h06;
	localparam logic [WD_W-1:0] WD_ONE    = 8'h01;
	localparam logic [WD_W-1:0] WD_MAX    = 8'hFF;
	localparam logic [WD_W-1:0] WD_CLEAR  = 8'h00;
	localparam logic [SP_W-1:0] SP_ONE    = 4'h1;
	localparam logic [SP_W-1:0] SP_FULL   = 4'h8;
	localparam logic [2:0]      IDX_ONE   = 3'h1;

	localparam logic [AXI_AW-1:0] REG_CTRL  = 8'h00;
	localparam logic [AXI_AW-1:0] REG_PC    = 8'h04;
	localparam logic [AXI_AW-1:0] REG_ACC   = 8'h08;
	localparam logic [AXI_AW-1:0] REG_FLAGS = 8'h0C;
	localparam logic [AXI_AW-1:0] REG_STACK = 8'h10;
	localparam logic [AXI_AW-1:0] REG_WDT   = 8'h14;
	localparam int CTRL_RUN = 0;
	localparam int FB_ZERO  = 0;
	localparam int FB_CARRY = 1;
	localparam int FB_HC    = 2;
	localparam int FB_PDF   = 3;
	localparam int FB_TMO   = 4;
	localparam int FB_EMI   = 5;
	localparam int FB_HALT  = 6;
	localparam int FB_PRE1  = 7;
	localparam int FB_PRE2  = 8;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_RUN   = 4'h2,
		ST_EXTRA = 4'h4,
		ST_HALT  = 4'h8
	} mie_state_t;

	typedef struct packed {
		logic [DW-1:0] addr;
		logic [DW-1:0] wdata;
		logic          we;
	} mie_dmem_req_t;

	typedef struct packed {
		logic global_irq_enable;
		logic watchdog_timeout_flag;
		logic power_down_flag;
		logic half_carry_flag;
		logic carry;
		logic zero;
	} mie_flags_t;
endpackage

// *** tb/mie_mem_model.sv ***
`timescale 1ns/10ps
module mie_mem_model (
	input  wire logic                   clk_i,
	input  wire logic [mie_pkg::PC_W-1:0] prog_addr_i,
	output      logic [mie_pkg::IW-1:0]   prog_data_o,
	input  wire mie_pkg::mie_dmem_req_t   dmem_req_i,
	output      logic [mie_pkg::DW-1:0]   dmem_rdata_o
);
	import mie_pkg::*;
	// plain arrays so the bench can preload them between runs
	logic [IW-1:0] prog [0:2047];
	logic [DW-1:0] dmem [0:255];
	assign prog_data_o = prog[prog_addr_i];
	assign dmem_rdata_o = dmem[dmem_req_i.addr];
	always @(posedge clk_i)
	begin
		if (dmem_req_i.we)
		begin
			dmem[dmem_req_i.addr] <= dmem_req_i.wdata;
		end
	end
endmodule

// *** tb/tb_mcu_instruction_execute.sv ***
`timescale 1ns/10ps
module tb_mcu_instruction_execute;
	import mie_pkg::*;
	typedef struct packed {
		logic [4:0] op;
		logic [7:0] m;
		logic [7:0] a;
		logic [7:0] f;
		logic [7:0] ea;
		logic [7:0] em;
		logic [8:0] ef;
	} mie_row_t;
	logic              clk_i = 1'b0, rst_n_i = 1'b0;
	logic [PC_W-1:0]   prog_addr_o;
	logic [IW-1:0]     prog_data_i;
	mie_dmem_req_t     dmem_req_o;
	logic [DW-1:0]     dmem_rdata_i;
	logic [AXI_AW-1:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
	logic [31:0]       s_axi_wdata_i = 32'h0, s_axi_rdata_o, d;
	logic [3:0]        s_axi_wstrb_i = 4'hF;
	logic [1:0]        s_axi_bresp_o, s_axi_rresp_o, resp;
	logic              s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
	logic              s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, halted_o;
	logic              s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	logic              s_axi_arready_o, s_axi_rvalid_o;
	int                errors = 0, checks = 0, cyc = 0, n;
	mie_row_t          r;
	logic [4:0]        exits [3] = '{OP_SUB_EXIT, OP_EXIT_LIT, OP_IRQ_EXIT};
	mie_row_t          rows [20] = '{
		'{OP_IDLE, 8'h5A, 8'h33, 8'h27, 8'h33, 8'h5A, 9'h027},
		'{OP_MEM_INVERT, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 9'h001},
		'{OP_INV_ACC, 8'h0F, 8'h00, 8'h01, 8'hF0, 8'h0F, 9'h000},
		'{OP_BCD_ADJ, 8'hFF, 8'h9A, 8'h00, 8'h9A, 8'h00, 9'h002},
		'{OP_BCD_ADJ, 8'hFF, 8'h42, 8'h05, 8'h42, 8'h48, 9'h005},
		'{OP_BCD_ADJ, 8'hFF, 8'h1A, 8'h06, 8'h1A, 8'h70, 9'h006},
		'{OP_MEM_MINUS, 8'h01, 8'h00, 8'h02, 8'h00, 8'h00, 9'h003},
		'{OP_MINUS_ACC, 8'h00, 8'h00, 8'h01, 8'hFF, 8'h00, 9'h000},
		'{OP_MEM_PLUS, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 9'h001},
		'{OP_PLUS_ACC, 8'h7F, 8'h00, 8'h01, 8'h80, 8'h7F, 9'h000},
		'{OP_LOAD_ACC, 8'h00, 8'h55, 8'h02, 8'h00, 8'h00, 9'h002},
		'{OP_LOAD_IMM, 8'hA5, 8'h00, 8'h00, 8'hA5, 8'hA5, 9'h000},
		'{OP_STORE_ACC, 8'h00, 8'h3C, 8'h21, 8'h3C, 8'h3C, 9'h021},
		'{OP_UNION_ACC, 8'hF0, 8'h0F, 8'h01, 8'hFF, 8'hF0, 9'h000},
		'{OP_UNION_IMM, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 9'h001},
		'{OP_UNION_MEM, 8'h18, 8'h81, 8'h00, 8'h81, 8'h99, 9'h000},
		'{OP_ROT_MEM, 8'h81, 8'h00, 8'h00, 8'h00, 8'h03, 9'h000},
		'{OP_ROT_ACC, 8'h80, 8'h00, 8'h03, 8'h01, 8'h80, 9'h003},
		'{OP_PRECLR1, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 9'h080},
		'{OP_PRECLR2, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 9'h000}};
	mie_core DUT (.clk_i, .rst_n_i, .prog_addr_o, .prog_data_i, .dmem_req_o, .dmem_rdata_i,
		.halted_o, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
		.s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
		.s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
		.s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i);
	mie_mem_model mem (.clk_i(clk_i), .prog_addr_i(prog_addr_o), .prog_data_o(prog_data_i),
		.dmem_req_i(dmem_req_o), .dmem_rdata_o(dmem_rdata_i));
	always #25 clk_i = ~clk_i;
	task automatic close_out;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
		begin
			$display("Test passed");
		end
		else
		begin
			$display("Test failed");
		end
		$finish;
	endtask
	// run takes a few thousand clocks; the ceiling only catches a hang
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			close_out();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= v;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		while (!(ad && wd))
		begin
			@(posedge clk_i);
			if (!ad && s_axi_awready_o)
			begin
				ad = 1'b1;
				s_axi_awvalid_i <= 1'b0;
			end
			if (!wd && s_axi_wready_o)
			begin
				wd = 1'b1;
				s_axi_wvalid_i <= 1'b0;
			end
		end
		do @(posedge clk_i); while (s_axi_bvalid_o !== 1'b1);
		resp = s_axi_bresp_o;
		s_axi_bready_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do @(posedge clk_i); while (s_axi_arready_o !== 1'b1);
		s_axi_arvalid_i <= 1'b0;
		do @(posedge clk_i); while (s_axi_rvalid_o !== 1'b1);
		d = s_axi_rdata_o;
		resp = s_axi_rresp_o;
		s_axi_rready_i <= 1'b0;
	endtask
	initial
	begin
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(REG_FLAGS);
		chk("reset flags", 32'h0, d);
		rd(8'h18);
		chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
		wr(8'h18, 32'h1);
		chk("unmapped wresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
		foreach (rows[i])
		begin
			r = rows[i];
			wr(REG_CTRL, 32'h0);
			wr(REG_PC, 32'h0);
			wr(REG_ACC, {24'h0, r.a});
			wr(REG_FLAGS, {24'h0, r.f});
			mem.dmem[8'h20] = r.m;
			mem.prog[0] = {r.op, 3'h0,
				(r.op == OP_LOAD_IMM || r.op == OP_UNION_IMM) ? r.m : 8'h20};
			mem.prog[1] = 16'h0000;
			mem.prog[2] = {OP_BRANCH, 11'h002};
			wr(REG_CTRL, 32'h1);
			repeat (40) @(posedge clk_i);
			rd(REG_ACC);
			chk("acc", {24'h0, r.ea}, d);
			rd(REG_FLAGS);
			chk("flags", {23'h0, r.ef}, d);
			chk("mem", {24'h0, r.em}, {24'h0, mem.dmem[8'h20]});
			if (r.op == OP_PRECLR2)
			begin
				rd(REG_WDT);
				chk("wdt", 32'h0, d);
			end
		end
		wr(REG_CTRL, 32'h0);
		wr(REG_PC, 32'h0);
		mem.prog[0] = 16'h0000;
		mem.prog[1] = {OP_BRANCH, 11'h000};
		wr(REG_CTRL, 32'h1);
		do @(posedge clk_i); while (prog_addr_o !== 11'h001);
		n = 0;
		while (prog_addr_o !== 11'h000)
		begin
			@(posedge clk_i);
			n++;
		end
		chk("branch clocks", 32'd8, n);
		n = 0;
		while (prog_addr_o !== 11'h001)
		begin
			@(posedge clk_i);
			n++;
		end
		chk("idle clocks", 32'd4, n);
		foreach (exits[k])
		begin
			wr(REG_CTRL, 32'h0);
			wr(REG_ACC, 32'h0);
			wr(REG_FLAGS, 32'h0);
			wr(REG_STACK, 32'h5);
			wr(REG_PC, 32'h0);
			repeat (300) @(posedge clk_i);
			mem.prog[0] = {exits[k], 11'h077};
			mem.prog[5] = {OP_POWER_DOWN, 11'h000};
			wr(REG_CTRL, 32'h1);
			do @(posedge clk_i); while (halted_o !== 1'b1);
			rd(REG_PC);
			chk("pc", 32'h6, d);
			rd(REG_ACC);
			chk("acc", (exits[k] == OP_EXIT_LIT) ? 32'h77 : 32'h0, d);
			rd(REG_FLAGS);
			chk("flags", (exits[k] == OP_IRQ_EXIT) ? 32'h68 : 32'h48, d);
			rd(REG_WDT);
			chk("wdt", 32'h0, d);
		end
		wr(REG_CTRL, 32'h0);
		wr(REG_ACC, 32'h5);
		chk("halted", 32'h0, {31'h0, halted_o});
		wr(REG_PC, 32'h0);
		mem.dmem[PCL_ADDR] = 8'hEE;
		mem.prog[0] = {OP_STORE_ACC, 3'h0, PCL_ADDR};
		wr(REG_CTRL, 32'h1);
		do @(posedge clk_i); while (halted_o !== 1'b1);
		rd(REG_PC);
		chk("pcl pc", 32'h6, d);
		chk("pcl mem", 32'hEE, {24'h0, mem.dmem[PCL_ADDR]});
		close_out();
	end
endmodule
